// ===== src/tmr_pair.sv
// Two timer/counters with AXI4-Lite registers, tick divider and pin sampling
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_pair (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire tmr_pkg::axil_req_s s_req,
   output tmr_pkg::axil_rsp_s s_rsp,
   // External pins
   input wire logic t0_pin,
   input wire logic t1_pin,
   input wire logic ext_irq0_pin,
   input wire logic ext_irq1_pin,
   // CPU interrupt side and timer 1 baud tick
   input wire logic irq_ack_t0,
   input wire logic irq_ack_t1,
   output logic t0_irq,
   output logic t1_irq,
   output logic t1_baud_tick
);
   function automatic logic [2:0] reg_idx(input logic [31:0] a);
      if (a == `OFS_CTRL) reg_idx = `IDX_CTRL;
      else if (a == `OFS_MODE) reg_idx = `IDX_MODE;
      else if (a == `OFS_T0L) reg_idx = `IDX_T0L;
      else if (a == `OFS_T0H) reg_idx = `IDX_T0H;
      else if (a == `OFS_T1L) reg_idx = `IDX_T1L;
      else if (a == `OFS_T1H) reg_idx = `IDX_T1H;
      else if (a == `OFS_IEN) reg_idx = `IDX_IEN;
      else reg_idx = `IDX_NONE;
   endfunction : reg_idx

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and peripheral tick

   logic [3:0] sync1_q, sync2_q;
   logic [1:0] samp_q;
   logic [1:0] irqp_q;
   logic [2:0] div_q;
   wire [3:0] pins = {ext_irq1_pin, ext_irq0_pin, t1_pin, t0_pin};
   wire [1:0] cnt_pin_s = sync2_q[1:0];
   wire [1:0] irq_pin_s = sync2_q[3:2];
   wire periph_tick = div_q == `PER_CLKS - 3'h1;
   wire [1:0] cnt_fall = {2{periph_tick}} & samp_q & ~cnt_pin_s;
   wire [1:0] irq_fall = irqp_q & ~irq_pin_s;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         irqp_q <= 2'h0;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
         irqp_q <= irq_pin_s;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= 3'h0;
         samp_q <= 2'h0;
      end else begin
         div_q <= periph_tick ? 3'h0 : div_q + 3'h1;
         if (periph_tick) samp_q <= cnt_pin_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave

   logic aw_q, w_q, bvalid_q, rvalid_q;
   logic [31:0] awaddr_q, wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [7:0] ctl_q, ctl_d, mode_q, ien_q;
   logic [7:0] t0l, t0h, t1l, t1h;

   wire wr_go = aw_q && w_q && !bvalid_q;
   wire [2:0] wi = reg_idx(awaddr_q);
   wire wr_b = wr_go && wstrb_q[0];
   wire rd_go = s_req.arvalid && !rvalid_q;
   wire [2:0] ri = reg_idx(s_req.araddr);
   wire [7:0] rd_byte = (ri == `IDX_CTRL) ? ctl_q :
                        (ri == `IDX_MODE) ? mode_q :
                        (ri == `IDX_T0L) ? t0l :
                        (ri == `IDX_T0H) ? t0h :
                        (ri == `IDX_T1L) ? t1l :
                        (ri == `IDX_T1H) ? t1h :
                        (ri == `IDX_IEN) ? ien_q : `RST_BYTE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_req.awvalid && s_rsp.awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_req.awaddr;
         end else if (wr_go) begin
            aw_q <= 1'b0;
         end
         if (s_req.wvalid && s_rsp.wready) begin
            w_q <= 1'b1;
            wdata_q <= s_req.wdata;
            wstrb_q <= s_req.wstrb;
         end else if (wr_go) begin
            w_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `RESP_OKAY;
      end else begin
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wi == `IDX_NONE) ? `RESP_DECERR : `RESP_OKAY;
         end else if (s_req.bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= (ri == `IDX_NONE) ? `RESP_DECERR : `RESP_OKAY;
         end else if (s_req.rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_rsp.awready = !aw_q && !bvalid_q;
   assign s_rsp.wready = !w_q && !bvalid_q;
   assign s_rsp.bvalid = bvalid_q;
   assign s_rsp.bresp = bresp_q;
   assign s_rsp.arready = !rvalid_q;
   assign s_rsp.rvalid = rvalid_q;
   assign s_rsp.rdata = rdata_q;
   assign s_rsp.rresp = rresp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Run control, gating and sources

   // Timer 1 takes the upper mode nibble
   wire tmr_pkg::tmr_cfg_s t0c = tmr_pkg::tmr_cfg_s'(mode_q[3:0]);
   wire tmr_pkg::tmr_cfg_s t1c = tmr_pkg::tmr_cfg_s'(mode_q[7:4]);
   wire tmr_pkg::mode_e t0_mode = tmr_pkg::mode_e'(t0c.mode);
   wire tmr_pkg::mode_e t1_mode = tmr_pkg::mode_e'(t1c.mode);
   wire t0_split = t0_mode == tmr_pkg::MODE_SPLIT;
   // Split timer 0 owns timer 1's run bit, so timer 1 free-runs
   wire t1_run = t0_split || ctl_q[`CTL_T1_RUN];
   // Gate needs irq pin high as well as run
   wire t0_en = ctl_q[`CTL_T0_RUN] && (!t0c.gate || irq_pin_s[0]);
   wire t1_en = t1_run && (!t1c.gate || irq_pin_s[1]);
   // Single tick enable qualifies every increment
   wire t0_inc = t0_en && (t0c.src ? cnt_fall[0] : periph_tick);
   wire t1_inc = t1_en && (t1c.src ? cnt_fall[1] : periph_tick);
   // High half counts ticks under timer 1 run bit
   wire t0_inc_hi = t0_split && ctl_q[`CTL_T1_RUN] && periph_tick;
   wire t0_ovf, t0_ovf_hi, t1_ovf;
   wire t1_flag_set = t0_split ? t0_ovf_hi : t1_ovf;

   tmr_unit #(.HAS_SPLIT(1'b1)) u_t0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .mode(t0_mode),
      .inc_lo(t0_inc),
      .inc_hi(t0_inc_hi),
      .wr_lo(wr_b && wi == `IDX_T0L),
      .wr_hi(wr_b && wi == `IDX_T0H),
      .wdata(wdata_q[7:0]),
      .cnt_lo(t0l),
      .cnt_hi(t0h),
      .ovf(t0_ovf),
      .ovf_hi(t0_ovf_hi)
   );

   // Timer 1 has no split and holds in mode 3
   tmr_unit #(.HAS_SPLIT(1'b0)) u_t1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .mode(t1_mode),
      .inc_lo(t1_inc),
      .inc_hi(1'b0),
      .wr_lo(wr_b && wi == `IDX_T1L),
      .wr_hi(wr_b && wi == `IDX_T1H),
      .wdata(wdata_q[7:0]),
      .cnt_lo(t1l),
      .cnt_hi(t1h),
      .ovf(t1_ovf),
      .ovf_hi()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control register, flags and interrupt requests

   always_comb begin
      ctl_d = ctl_q;
      if (wr_b && wi == `IDX_CTRL) ctl_d = wdata_q[7:0];
      if (irq_ack_t0) ctl_d[`CTL_T0_OVF] = 1'b0;
      if (irq_ack_t1) ctl_d[`CTL_T1_OVF] = 1'b0;
      // Edge mode latches falling edge, level mode sets the flag while the pin is low
      if (ctl_q[`CTL_X0_EDGE] ? irq_fall[0] : !irq_pin_s[0]) ctl_d[`CTL_X0_FLAG] = 1'b1;
      if (ctl_q[`CTL_X1_EDGE] ? irq_fall[1] : !irq_pin_s[1]) ctl_d[`CTL_X1_FLAG] = 1'b1;
      // Wrap sets flag; set beats any clear
      if (t0_ovf) ctl_d[`CTL_T0_OVF] = 1'b1;
      if (t1_flag_set) ctl_d[`CTL_T1_OVF] = 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_q <= `RST_BYTE;
         mode_q <= `RST_BYTE;
         ien_q <= `RST_BYTE;
      end else begin
         ctl_q <= ctl_d;
         if (wr_b && wi == `IDX_MODE) mode_q <= wdata_q[7:0];
         if (wr_b && wi == `IDX_IEN) ien_q <= wdata_q[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t0_irq <= 1'b0;
         t1_irq <= 1'b0;
         t1_baud_tick <= 1'b0;
      end else begin
         t0_irq <= ctl_q[`CTL_T0_OVF] && ien_q[`IEN_T0] && ien_q[`IEN_ALL];
         t1_irq <= ctl_q[`CTL_T1_OVF] && ien_q[`IEN_T1] && ien_q[`IEN_ALL];
         // Timer 1 overflow drives the baud clock
         t1_baud_tick <= t1_ovf;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence tick_gap;
      !periph_tick [*5] ##1 periph_tick;
   endsequence

   tick_period_a: assert property (periph_tick |=> tick_gap)
      else $error("peripheral tick not every six clocks");
   pin_edge_a: assert property (
      (t0c.src && t0_en && !t0_split && t0_inc) |-> (periph_tick && !cnt_pin_s[0]
      && $past(cnt_pin_s[0], `PER_CLKS)))
      else $error("counter stepped without sampled falling edge");
   gate_block_a: assert property (
      (t0c.gate && !irq_pin_s[0]) |-> !t0_inc)
      else $error("gated timer counted with pin low");
   flag_set_a: assert property (
      (t0_ovf || t1_flag_set) |=> (ctl_q[`CTL_T0_OVF] || !$past(t0_ovf))
      && (ctl_q[`CTL_T1_OVF] || !$past(t1_flag_set)))
      else $error("overflow flag not set");
   ack_clear_a: assert property (
      (irq_ack_t0 && !t0_ovf && !(wr_b && wi == `IDX_CTRL)) |=> !ctl_q[`CTL_T0_OVF])
      else $error("flag survived vectoring");
   irq_gate_a: assert property (
      t0_irq |-> $past(ien_q[`IEN_ALL] && ien_q[`IEN_T0] && ctl_q[`CTL_T0_OVF]))
      else $error("interrupt passed disabled enable");
   split_flag_a: assert property (
      (t0_split && t0_ovf_hi) |=> ctl_q[`CTL_T1_OVF])
      else $error("split high overflow missed timer 1 flag");
   baud_tick_a: assert property (t1_ovf |=> t1_baud_tick)
      else $error("baud tick missing");
endmodule : tmr_pair

// ===== src/tmr_cfg.svh
// Register offsets, field positions, reset values and tick counts for the timer pair
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// Byte offsets on the register bus
`define OFS_CTRL 32'h0000_0000
`define OFS_MODE 32'h0000_0004
`define OFS_T0L 32'h0000_0008
`define OFS_T0H 32'h0000_000c
`define OFS_T1L 32'h0000_0010
`define OFS_T1H 32'h0000_0014
`define OFS_IEN 32'h0000_0018

// Decoded register index
`define IDX_CTRL 3'h0
`define IDX_MODE 3'h1
`define IDX_T0L 3'h2
`define IDX_T0H 3'h3
`define IDX_T1L 3'h4
`define IDX_T1H 3'h5
`define IDX_IEN 3'h6
`define IDX_NONE 3'h7

// timer_control_reg bits
`define CTL_T1_OVF 7
`define CTL_T1_RUN 6
`define CTL_T0_OVF 5
`define CTL_T0_RUN 4
`define CTL_X1_FLAG 3
`define CTL_X1_EDGE 2
`define CTL_X0_FLAG 1
`define CTL_X0_EDGE 0

// irq_enable_reg bits
`define IEN_ALL 7
`define IEN_T1 3
`define IEN_T0 1

`define RST_BYTE 8'h00
`define PER_CLKS 3'h6
`define PRESC_MAX 5'h1f
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ===== src/tmr_pkg.sv
// Types shared by the timer pair
package tmr_pkg;
   typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD, MODE_SPLIT} mode_e;
   typedef struct packed {
      logic gate;
      logic src;
      logic [1:0] mode;
   } tmr_cfg_s;
   typedef struct packed {
      logic [31:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [31:0] araddr;
      logic arvalid;
      logic rready;
   } axil_req_s;
   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } axil_rsp_s;
endpackage : tmr_pkg

// ===== src/tmr_unit.sv
// One timer/counter: count bytes and mode datapath
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_unit #(
   parameter bit HAS_SPLIT = 1'b0
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire tmr_pkg::mode_e mode,
   input wire logic inc_lo,
   input wire logic inc_hi,
   // Software writes
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [7:0] wdata,
   // Status
   output logic [7:0] cnt_lo,
   output logic [7:0] cnt_hi,
   output logic ovf,
   output logic ovf_hi
);
   logic [7:0] lo_q, lo_d, hi_q, hi_d;
   wire lo5_full = lo_q[4:0] == `PRESC_MAX;
   wire lo_full = lo_q == 8'hff;
   wire hi_full = hi_q == 8'hff;

   always_comb begin
      lo_d = lo_q;
      hi_d = hi_q;
      ovf = 1'b0;
      ovf_hi = 1'b0;
      case (mode)
         tmr_pkg::MODE_13BIT: if (inc_lo) begin
            lo_d[4:0] = lo_q[4:0] + 5'h01;
            if (lo5_full) begin
               hi_d = hi_q + 8'h01;
               ovf = hi_full;
            end
         end
         tmr_pkg::MODE_16BIT: if (inc_lo) begin
            lo_d = lo_q + 8'h01;
            if (lo_full) begin
               hi_d = hi_q + 8'h01;
               ovf = hi_full;
            end
         end
         tmr_pkg::MODE_RELOAD: if (inc_lo) begin
            lo_d = lo_full ? hi_q : lo_q + 8'h01;
            ovf = lo_full;
         end
         // Two 8-bit halves, or hold when split is not offered
         default: if (HAS_SPLIT) begin
            if (inc_lo) begin
               lo_d = lo_q + 8'h01;
               ovf = lo_full;
            end
            if (inc_hi) begin
               hi_d = hi_q + 8'h01;
               ovf_hi = hi_full;
            end
         end
      endcase
      if (wr_lo) lo_d = wdata;
      if (wr_hi) hi_d = wdata;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lo_q <= `RST_BYTE;
         hi_q <= `RST_BYTE;
      end else begin
         lo_q <= lo_d;
         hi_q <= hi_d;
      end
   end

   assign cnt_lo = lo_q;
   assign cnt_hi = hi_q;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   presc_carry_a: assert property (
      (mode == tmr_pkg::MODE_13BIT && inc_lo && lo5_full && !wr_lo && !wr_hi)
      |=> (lo_q[4:0] == 5'h00 && hi_q == $past(hi_q) + 8'h01))
      else $error("prescaler carry lost");
   upper_hold_a: assert property (
      (mode == tmr_pkg::MODE_13BIT && !wr_lo) |=> $stable(lo_q[7:5]))
      else $error("upper low bits counted");
   cascade_carry_a: assert property (
      (mode == tmr_pkg::MODE_16BIT && inc_lo && lo_full && !wr_lo && !wr_hi)
      |=> (lo_q == 8'h00 && hi_q == $past(hi_q) + 8'h01))
      else $error("16-bit carry wrong");
   reload_value_a: assert property (
      (mode == tmr_pkg::MODE_RELOAD && inc_lo && lo_full && !wr_lo && !wr_hi)
      |-> ovf ##1 (lo_q == $past(hi_q) && $stable(hi_q)))
      else $error("reload wrong");
   split_low_a: assert property (
      (HAS_SPLIT && mode == tmr_pkg::MODE_SPLIT && inc_lo && lo_full) |-> ovf)
      else $error("split low overflow missed");
   halt_hold_a: assert property (
      (!HAS_SPLIT && mode == tmr_pkg::MODE_SPLIT && !wr_lo && !wr_hi)
      |=> ($stable(lo_q) && $stable(hi_q) && !$past(ovf)))
      else $error("halted timer moved");
endmodule : tmr_unit

// ===== dv/cpu_irq_model.sv
// CPU-side model: vectors to pending timer interrupts and acknowledges them
`timescale 1ns/1ps
module cpu_irq_model #(
   parameter int DELAY = 2
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Interrupt lines and control
   input wire logic [1:0] irq,
   input wire logic en,
   output logic [1:0] ack
);
   logic [1:0] busy_q;
   int wait_q [2];

   always @(posedge aclk) begin
      for (int i = 0; i < 2; i++) begin
         if (!aresetn) begin
            ack[i] <= 1'b0;
            busy_q[i] <= 1'b0;
            wait_q[i] <= 0;
         end else if (busy_q[i]) begin
            // One ack per request: wait for the line to drop
            ack[i] <= 1'b0;
            busy_q[i] <= irq[i];
         end else if (irq[i] && en) begin
            ack[i] <= wait_q[i] == DELAY;
            busy_q[i] <= wait_q[i] == DELAY;
            wait_q[i] <= (wait_q[i] == DELAY) ? 0 : wait_q[i] + 1;
         end else begin
            ack[i] <= 1'b0;
         end
      end
   end
endmodule : cpu_irq_model

// ===== dv/tmr_pair_tb.sv
// Self-checking bench for the timer pair
`timescale 1ns/1ps
module tmr_pair_tb;
   localparam logic [31:0] a_ctrl = 32'h0000_0000;
   localparam logic [31:0] a_mode = 32'h0000_0004;
   localparam logic [31:0] a_t0l = 32'h0000_0008;
   localparam logic [31:0] a_t0h = 32'h0000_000c;
   localparam logic [31:0] a_t1l = 32'h0000_0010;
   localparam logic [31:0] a_t1h = 32'h0000_0014;
   localparam logic [31:0] a_ien = 32'h0000_0018;
   typedef struct {
      int u;
      logic [7:0] mode;
      logic [7:0] th;
      logic [7:0] tl;
      int n;
      logic [7:0] etl;
      logic [7:0] eth;
      logic etf;
   } row_s;
   // Counter-source rows: exact edge counts keep results deterministic
   row_s rows [7] = '{
      '{0, 8'h05, 8'h12, 8'hfe, 3, 8'h01, 8'h13, 1'b0},
      '{0, 8'h05, 8'hff, 8'hff, 1, 8'h00, 8'h00, 1'b1},
      '{0, 8'h04, 8'h05, 8'hff, 1, 8'he0, 8'h06, 1'b0},
      '{0, 8'h04, 8'hff, 8'h1f, 1, 8'h00, 8'h00, 1'b1},
      '{0, 8'h06, 8'hfd, 8'hfe, 2, 8'hfd, 8'hfd, 1'b1},
      '{1, 8'h50, 8'hff, 8'hfe, 2, 8'h00, 8'h00, 1'b1},
      '{1, 8'h60, 8'h80, 8'hff, 1, 8'h80, 8'h80, 1'b1}};
   logic aclk;
   logic aresetn;
   tmr_pkg::axil_req_s req;
   tmr_pkg::axil_rsp_s rsp;
   logic [1:0] pin;
   logic [1:0] eirq;
   logic [1:0] ack;
   logic [1:0] irq;
   logic baud;
   logic ack_en;
   logic [31:0] d;
   logic [31:0] base;
   int error_cnt;
   int n_tests;
   int cyc;
   int baud_n;
   int baud0;

   tmr_pair dut (
      .aclk(aclk), .aresetn(aresetn), .s_req(req), .s_rsp(rsp),
      .t0_pin(pin[0]), .t1_pin(pin[1]), .ext_irq0_pin(eirq[0]), .ext_irq1_pin(eirq[1]),
      .irq_ack_t0(ack[0]), .irq_ack_t1(ack[1]), .t0_irq(irq[0]), .t1_irq(irq[1]),
      .t1_baud_tick(baud)
   );
   cpu_irq_model #(.DELAY(2)) cpu (
      .aclk(aclk), .aresetn(aresetn), .irq(irq), .en(ack_en), .ack(ack)
   );

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic results();
      $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   // Hang guard, and baud pulse tally
   always @(posedge aclk) begin
      cyc++;
      if (baud === 1'b1) begin
         baud_n++;
      end
      if (cyc == 30000) begin
         error_cnt++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [7:0] v, input logic [1:0] er = 2'h0);
      logic aw_left;
      logic w_left;
      aw_left = 1'b1;
      w_left = 1'b1;
      req.awaddr <= a;
      req.wdata <= {24'h00_0000, v};
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      while (aw_left || w_left) begin
         @(posedge aclk);
         if (aw_left && rsp.awready === 1'b1) begin
            aw_left = 1'b0;
            req.awvalid <= 1'b0;
         end
         if (w_left && rsp.wready === 1'b1) begin
            w_left = 1'b0;
            req.wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (rsp.bvalid !== 1'b1);
      chk(32'(rsp.bresp), 32'(er));
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] v, input logic [1:0] er = 2'h0);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      do @(posedge aclk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge aclk); while (rsp.rvalid !== 1'b1);
      v = rsp.rdata;
      chk(32'(rsp.rresp), 32'(er));
   endtask : rd

   task automatic rc(input logic [31:0] a, input logic [7:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(v, {24'h00_0000, e});
   endtask : rc

   // Each level held over two peripheral cycles so every level is sampled
   task automatic pulse(input int u, input int n);
      repeat (n) begin
         pin[u] <= 1'b1;
         repeat (14) @(posedge aclk);
         pin[u] <= 1'b0;
         repeat (14) @(posedge aclk);
      end
   endtask : pulse

   initial begin
      req = '0;
      req.wstrb = 4'hf;
      // Ready held high: every answer is taken the cycle it appears
      req.bready = 1'b1;
      req.rready = 1'b1;
      pin = 2'b00;
      eirq = 2'b11;
      ack_en = 1'b0;
      aresetn = 1'b0;
      error_cnt = 0;
      n_tests = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Pin flags may latch while the synchronisers flush, so mask them
      rd(a_ctrl, d);
      chk(d & 32'h0000_00f5, 32'h0000_0000);
      for (int i = 1; i < 7; i++) begin
         rc(32'(i * 4), 8'h00);
      end
      rd(32'h0000_001c, d, 2'h3);
      chk(d, 32'h0000_0000);
      wr(32'h0000_001c, 8'h5a, 2'h3);
      $display("test reset finished");

      for (int i = 0; i < 7; i++) begin
         base = (rows[i].u == 1) ? a_t1l : a_t0l;
         wr(a_ctrl, 8'h00);
         wr(a_mode, rows[i].mode);
         wr(base, rows[i].tl);
         wr(base + 32'h0000_0004, rows[i].th);
         wr(a_ctrl, (rows[i].u == 1) ? 8'h40 : 8'h10);
         pulse(rows[i].u, rows[i].n);
         rc(base, rows[i].etl);
         rc(base + 32'h0000_0004, rows[i].eth);
         rd(a_ctrl, d);
         chk(32'(d[(rows[i].u == 1) ? 7 : 5]), 32'(rows[i].etf));
         $display("test row %0d finished", i);
      end

      wr(a_ctrl, 8'h00);
      wr(a_mode, 8'h09);
      wr(a_t0l, 8'h00);
      wr(a_t0h, 8'h00);
      eirq[0] <= 1'b0;
      wr(a_ctrl, 8'h10);
      repeat (60) @(posedge aclk);
      rc(a_t0l, 8'h00);
      eirq[0] <= 1'b1;
      repeat (60) @(posedge aclk);
      wr(a_ctrl, 8'h00);
      rd(a_t0l, d);
      chk(32'(d >= 9 && d <= 11), 32'h0000_0001);
      $display("test gate finished");

      wr(a_mode, 8'h0a);
      wr(a_t0h, 8'hfe);
      wr(a_t0l, 8'hfe);
      wr(a_ien, 8'h02);
      wr(a_ctrl, 8'h10);
      repeat (30) @(posedge aclk);
      eirq[0] <= 1'b0;
      repeat (10) @(posedge aclk);
      rd(a_ctrl, d);
      chk(d & 32'h0000_0020, 32'h0000_0020);
      chk(32'(irq[0]), 32'h0000_0000);
      wr(a_ien, 8'h82);
      repeat (3) @(posedge aclk);
      chk(32'(irq[0]), 32'h0000_0001);
      ack_en <= 1'b1;
      repeat (10) @(posedge aclk);
      chk(32'(irq[0]), 32'h0000_0000);
      rd(a_ctrl, d);
      chk(d & 32'h0000_0020, 32'h0000_0000);
      ack_en <= 1'b0;
      $display("test interrupt finished");

      wr(a_ctrl, 8'h00);
      wr(a_mode, 8'h33);
      wr(a_t1l, 8'h55);
      wr(a_t0l, 8'h00);
      wr(a_t0h, 8'hff);
      wr(a_ctrl, 8'h40);
      repeat (30) @(posedge aclk);
      rd(a_ctrl, d);
      chk(d & 32'h0000_00a0, 32'h0000_0080);
      rc(a_t1l, 8'h55);
      rc(a_t0l, 8'h00);
      $display("test split finished");

      wr(a_ien, 8'h88);
      repeat (3) @(posedge aclk);
      chk(32'(irq[1]), 32'h0000_0001);
      ack_en <= 1'b1;
      repeat (10) @(posedge aclk);
      chk(32'(irq[1]), 32'h0000_0000);
      ack_en <= 1'b0;
      // Timer 1 started by leaving mode 3 while timer 0 stays split
      wr(a_ctrl, 8'h00);
      wr(a_t1h, 8'hfe);
      wr(a_t1l, 8'hfe);
      wr(a_mode, 8'h23);
      baud0 = baud_n;
      repeat (30) @(posedge aclk);
      rd(a_ctrl, d);
      chk(d & 32'h0000_0080, 32'h0000_0000);
      chk(32'(baud_n - baud0 >= 2), 32'h0000_0001);
      $display("test split timer 1 finished");

      wr(a_ctrl, 8'h00);
      wr(a_mode, 8'h20);
      wr(a_t1h, 8'hfe);
      wr(a_t1l, 8'hfe);
      baud0 = baud_n;
      wr(a_ctrl, 8'h40);
      repeat (120) @(posedge aclk);
      wr(a_ctrl, 8'h00);
      chk(32'(baud_n - baud0 >= 9 && baud_n - baud0 <= 11), 32'h0000_0001);
      $display("test baud finished");

      // Reload byte rewritten while counting
      wr(a_mode, 8'h60);
      wr(a_t1h, 8'hfe);
      wr(a_t1l, 8'hfe);
      wr(a_ctrl, 8'h40);
      wr(a_t1h, 8'h10);
      pulse(1, 2);
      rc(a_t1l, 8'h10);
      rc(a_t1h, 8'h10);
      wr(a_ctrl, 8'h00);
      $display("test reload write finished");
      results();
   end
endmodule : tmr_pair_tb
